// ---- rtl/adc_seq_pkg.sv ----
/*
  Constants and types for the converter sequencer: register offsets, field positions,
  reset values and conversion cycle counts.
  Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
*/
// Contract
// - Writing start bit begins one conversion; bit reads one until hardware clears it.
// - Channel change during a conversion takes effect only after it completes.
// - Free-run mode converts continuously after one start, regardless of done flag.
// - Divider select sets prescale; prescaler runs while enabled, held reset otherwise.
// - A started conversion begins on the next rising converter clock edge.
// - Normal conversion lasts 13 converter cycles; first after enable lasts 25.
// - Sample-and-hold at 1.5 cycles normally, 13.5 cycles for first conversion.
// - Completion writes result, sets done flag, clears start bit in single mode.
// - Free-run mode starts next conversion immediately, start bit stays set.
// - Differential conversions align to half-rate clock: 13 cycles if low, 14 if high.
// - Automatic free-run differential conversions after the first take 14 cycles.
// - Selections pass through holding register, copied until start, then frozen.
// - Copying of selections resumes in the last cycle before done flag sets.
// - Free-run channel change after completion affects the result after next.
// - Enabled boundary-scan port overrides upper four analog inputs.
// - Low byte read blocks result updates until high byte read; flag still sets.
// - Selections have no effect while converter is disabled.
// - Ten-bit result right adjusted by default, left adjusted when selected.
`default_nettype none
package adc_seq_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFFS   = 4'h0;
  localparam logic [3:0] SEL_OFFS    = 4'h4;
  localparam logic [3:0] RESLO_OFFS  = 4'h8;
  localparam logic [3:0] RESHI_OFFS  = 4'hC;
  // Control register fields
  localparam int DIV_LSB    = 0;
  localparam int DONE_BIT   = 4;
  localparam int FREE_BIT   = 5;
  localparam int START_BIT  = 6;
  localparam int ENABLE_BIT = 7;
  // Selection register fields
  localparam int CHAN_LSB   = 0;
  localparam int LEFT_BIT   = 5;
  localparam int REF_LSB    = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET  = 8'h00;
  // Conversion timing in converter cycles, counted in half cycles
  localparam int NORMAL_CYCLES  = 13;
  localparam int FIRST_CYCLES   = 25;
  localparam int DIFF_CYCLES    = 14;
  localparam int NORMAL_SH_HALF = 3;
  localparam int FIRST_SH_HALF  = 27;
  // Channel codes at or above this value are differential
  localparam logic [4:0] DIFF_CHAN_MIN = 5'h08;
  localparam int CHAN_W = 5;
  localparam int REF_W  = 2;
  localparam int RES_W  = 10;
  typedef struct packed {
    logic [REF_W-1:0]  refSel;
    logic [CHAN_W-1:0] chan;
  } sel_t;
endpackage
`default_nettype wire

// ---- rtl/adc_conv_if.sv ----
/*
  Interface carrying the converter timing events from the timing core to the top.
  Assumes both ends run on sys_clk.
*/
`default_nettype none
interface adc_conv_if;
  logic       convEdge;    // Converter clock rising edge pulse
  logic       halfEdge;    // Converter clock falling edge pulse
  logic       halfRate;    // Half-rate sync clock level
  modport core (output convEdge, output halfEdge, output halfRate);
  modport user (input convEdge, input halfEdge, input halfRate);
endinterface
`default_nettype wire

// ---- rtl/adc_prescaler.sv ----
/*
  Converter clock prescaler: divides sys_clk by a power of two and marks edges.
  Assumes enable and divider select come from registers on sys_clk.
*/
`default_nettype none
module adc_prescaler #(
  parameter int CNT_W = 7
) (
  input  wire logic   sys_clk,     // System clock
  input  wire logic   srst,        // Sync reset, active high
  input  wire logic   enable,      // Converter enable
  input  wire logic [2:0] divSel,  // Divider select
  adc_conv_if.core    conv         // Edge events
);
  logic [CNT_W-1:0] cnt_ff;
  logic             convClk_ff;
  logic             halfRate_ff;
  logic             convEdge_ff;
  logic             halfEdge_ff;
  logic [CNT_W-1:0] halfPeriod;

  always_comb
  begin
    halfPeriod = (divSel == 3'h0) ? CNT_W'(1) : CNT_W'((1 << divSel) >> 1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable)
    begin
      cnt_ff      <= '0;
      convClk_ff  <= 1'b0;
      halfRate_ff <= 1'b0;
      convEdge_ff <= 1'b0;
      halfEdge_ff <= 1'b0;
    end
    else if (cnt_ff + CNT_W'(1) >= halfPeriod)
    begin
      cnt_ff      <= '0;
      convClk_ff  <= !convClk_ff;
      convEdge_ff <= !convClk_ff;
      halfEdge_ff <= convClk_ff;
      if (!convClk_ff)
      begin
        halfRate_ff <= !halfRate_ff;
      end
    end
    else
    begin
      cnt_ff      <= cnt_ff + CNT_W'(1);
      convEdge_ff <= 1'b0;
      halfEdge_ff <= 1'b0;
    end
  end

  assign conv.convEdge = convEdge_ff;
  assign conv.halfEdge = halfEdge_ff;
  assign conv.halfRate = halfRate_ff;
endmodule
`default_nettype wire

// ---- rtl/adc_conversion_sequencer.sv ----
/*
  Conversion sequencer top: AHB-Lite register slave, start/free-run control, conversion
  timing, selection buffering and result registers.
  Assumes an external analog core that samples on sampleHold and delivers convData.
*/
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`default_nettype none
module adc_conversion_sequencer (
  input  wire logic        sys_clk,       // System clock, 100 MHz
  input  wire logic        srst,          // Sync reset, active high
  input  wire logic        hsel,          // AHB select
  input  wire logic [31:0] haddr,         // AHB address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB ready in
  output logic      [31:0] hrdata,        // AHB read data
  output logic             hreadyout,     // AHB ready out
  output logic             hresp,         // AHB response
  input  wire logic [9:0]  convData,      // Result from analog core
  input  wire logic        scanEnable,    // Boundary-scan port enabled
  output logic      [4:0]  activeChan,    // Active channel selection
  output logic      [1:0]  activeRef,     // Active reference selection
  output logic             sampleHold,    // Sample-and-hold strobe
  output logic             convBusy,      // Conversion in progress
  output logic      [3:0]  upperPinOvr    // Upper analog pins overridden
);
  adc_conv_if conv ();

  logic [2:0]  divSel_ff;
  logic        enable_ff;
  logic        free_ff;
  logic        start_ff;
  logic        done_ff;
  adc_seq_pkg::sel_t hold_ff;
  adc_seq_pkg::sel_t active_ff;
  logic        left_ff;
  logic [9:0]  result_ff;
  logic        lock_ff;
  logic        firstConv_ff;
  logic        running_ff;
  logic        pending_ff;
  logic [2:0]  scanSync_ff;
  logic [5:0]  halfCnt_ff;
  logic [5:0]  endHalf_ff;
  logic        sampleHold_ff;
  logic        convBusy_ff;
  logic [3:0]  upperPinOvr_ff;
  logic [31:0] hrdata_ff;
  logic        wrPend_ff;
  logic        rdPend_ff;
  logic [3:0]  addr_ff;
  logic        addrOk_ff;
  logic        finish;
  logic        lastCycle;
  logic        wrCtrl;
  logic        wrSel;
  logic        rdLow;
  logic        rdHigh;
  logic        startNow;
  logic [5:0]  nxt_endHalf;

  function automatic logic isDiff(input logic [4:0] chan);
    isDiff = chan >= adc_seq_pkg::DIFF_CHAN_MIN;
  endfunction

  function automatic logic [5:0] halves(input int cycles);
    halves = 6'(2 * cycles);
  endfunction

  adc_prescaler #(
    .CNT_W (7)
  ) i_adc_prescaler (
    .sys_clk (sys_clk),
    .srst    (srst),
    .enable  (enable_ff),
    .divSel  (divSel_ff),
    .conv    (conv)
  );

  // Bus address phase capture, zero wait state
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= '0;
      addrOk_ff <= 1'b0;
    end
    else if (hready)
    begin
      wrPend_ff <= hsel && htrans[1] && hwrite;
      rdPend_ff <= hsel && htrans[1] && !hwrite;
      addr_ff   <= haddr[3:0];
      addrOk_ff <= (haddr[31:4] == '0);
    end
  end

  assign wrCtrl = wrPend_ff && addrOk_ff && (addr_ff == adc_seq_pkg::CTRL_OFFS);
  assign wrSel  = wrPend_ff && addrOk_ff && (addr_ff == adc_seq_pkg::SEL_OFFS);
  assign rdLow  = rdPend_ff && addrOk_ff && (addr_ff == adc_seq_pkg::RESLO_OFFS);
  assign rdHigh = rdPend_ff && addrOk_ff && (addr_ff == adc_seq_pkg::RESHI_OFFS);

  // Read data mux, registered one cycle into the data phase
  always_comb
  begin
    hrdata = hrdata_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hrdata_ff <= '0;
    end
    else if (hready && hsel && htrans[1] && !hwrite && haddr[31:4] == '0)
    begin
      unique case (haddr[3:0])
        adc_seq_pkg::CTRL_OFFS:
          hrdata_ff <= {24'h000000, enable_ff, start_ff, free_ff, done_ff, 1'b0, divSel_ff};
        adc_seq_pkg::SEL_OFFS:
          hrdata_ff <= {24'h000000, hold_ff.refSel, left_ff, hold_ff.chan};
        adc_seq_pkg::RESLO_OFFS:
          hrdata_ff <= left_ff ? {24'h000000, result_ff[1:0], 6'h00} : {24'h000000, result_ff[7:0]};
        adc_seq_pkg::RESHI_OFFS:
          hrdata_ff <= left_ff ? {24'h000000, result_ff[9:2]} : {24'h000000, 6'h00, result_ff[9:8]};
        default:
          hrdata_ff <= '0;
      endcase
    end
    else
    begin
      hrdata_ff <= '0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Control fields
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      divSel_ff <= adc_seq_pkg::CTRL_RESET[2:0];
      enable_ff <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::ENABLE_BIT];
      free_ff   <= adc_seq_pkg::CTRL_RESET[adc_seq_pkg::FREE_BIT];
    end
    else if (wrCtrl)
    begin
      divSel_ff <= hwdata[adc_seq_pkg::DIV_LSB +: 3];
      enable_ff <= hwdata[adc_seq_pkg::ENABLE_BIT];
      free_ff   <= hwdata[adc_seq_pkg::FREE_BIT];
    end
  end

  assign finish    = running_ff && conv.convEdge && (halfCnt_ff + 6'd1 == endHalf_ff);
  assign lastCycle = running_ff && (halfCnt_ff + 6'd2 >= endHalf_ff);

  // start bit set by software, held during conversion
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable_ff)
    begin
      start_ff <= 1'b0;
    end
    else if (wrCtrl && hwdata[adc_seq_pkg::START_BIT] && hwdata[adc_seq_pkg::ENABLE_BIT])
    begin
      start_ff <= 1'b1;
    end
    else if (finish && !free_ff)
    begin
      start_ff <= 1'b0;
    end
  end

  // done flag; set wins over write-one clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      done_ff <= 1'b0;
    end
    else if (finish)
    begin
      done_ff <= 1'b1;
    end
    else if (wrCtrl && hwdata[adc_seq_pkg::DONE_BIT])
    begin
      done_ff <= 1'b0;
    end
  end

  // wait for next converter clock rising edge
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable_ff)
    begin
      pending_ff <= 1'b0;
    end
    else if (wrCtrl && hwdata[adc_seq_pkg::START_BIT] && !running_ff && !start_ff)
    begin
      pending_ff <= 1'b1;
    end
    else if (conv.convEdge)
    begin
      pending_ff <= 1'b0;
    end
  end

  // free run restarts without regard to done flag
  assign startNow = (conv.convEdge && pending_ff) || (finish && free_ff);

  always_comb
  begin
    if (firstConv_ff && !finish)
    begin
      nxt_endHalf = halves(adc_seq_pkg::FIRST_CYCLES);
    end
    else if (isDiff(active_ff.chan) && (finish || conv.halfRate))
    begin
      nxt_endHalf = halves(adc_seq_pkg::DIFF_CYCLES);
    end
    else
    begin
      nxt_endHalf = halves(adc_seq_pkg::NORMAL_CYCLES);
    end
  end

  // Conversion sequencing in half converter cycles
  always_ff @(posedge sys_clk)
  begin
    if (srst || !enable_ff)
    begin
      running_ff   <= 1'b0;
      halfCnt_ff   <= '0;
      endHalf_ff   <= '0;
      firstConv_ff <= 1'b1;
    end
    else if (startNow)
    begin
      running_ff   <= 1'b1;
      halfCnt_ff   <= '0;
      endHalf_ff   <= nxt_endHalf;
      firstConv_ff <= firstConv_ff && !finish;
    end
    else if (running_ff && (conv.convEdge || conv.halfEdge))
    begin
      halfCnt_ff <= halfCnt_ff + 6'd1;
      if (finish)
      begin
        running_ff   <= 1'b0;
        firstConv_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sampleHold_ff <= 1'b0;
    end
    else
    begin
      sampleHold_ff <= running_ff && conv.halfEdge &&
        (halfCnt_ff + 6'd1 == (firstConv_ff ? 6'(adc_seq_pkg::FIRST_SH_HALF) :
                                              6'(adc_seq_pkg::NORMAL_SH_HALF)));
    end
  end

  // Holding register written by software
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hold_ff.chan   <= adc_seq_pkg::SEL_RESET[adc_seq_pkg::CHAN_LSB +: adc_seq_pkg::CHAN_W];
      hold_ff.refSel <= adc_seq_pkg::SEL_RESET[adc_seq_pkg::REF_LSB +: adc_seq_pkg::REF_W];
      left_ff <= adc_seq_pkg::SEL_RESET[adc_seq_pkg::LEFT_BIT];
    end
    else if (wrSel)
    begin
      hold_ff.chan   <= hwdata[adc_seq_pkg::CHAN_LSB +: adc_seq_pkg::CHAN_W];
      hold_ff.refSel <= hwdata[adc_seq_pkg::REF_LSB +: adc_seq_pkg::REF_W];
      left_ff        <= hwdata[adc_seq_pkg::LEFT_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      active_ff <= '0;
    end
    else if (enable_ff && (!running_ff || lastCycle) && !startNow)
    begin
      active_ff <= hold_ff;
    end
  end

  // result blocked between low and high byte reads
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      lock_ff <= 1'b0;
    end
    else if (rdLow)
    begin
      lock_ff <= 1'b1;
    end
    else if (rdHigh)
    begin
      lock_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      result_ff <= '0;
    end
    else if (finish && !lock_ff)
    begin
      result_ff <= convData;
    end
  end

  // Scan enable from another domain, three stages
  always_ff @(posedge sys_clk)
  begin
    scanSync_ff <= {scanSync_ff[1:0], scanEnable};
  end

  // Status outputs
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      convBusy_ff    <= 1'b0;
      upperPinOvr_ff <= 4'h0;
    end
    else
    begin
      convBusy_ff    <= running_ff;
      if (scanSync_ff[1] == scanSync_ff[2])
      begin
        upperPinOvr_ff <= {4{scanSync_ff[2]}};
      end
    end
  end

  assign activeChan  = active_ff.chan;
  assign activeRef   = active_ff.refSel;
  assign sampleHold  = sampleHold_ff;
  assign convBusy    = convBusy_ff;
  assign upperPinOvr = upperPinOvr_ff;
endmodule
`default_nettype wire

// ---- test/adc_seq_chk.sv ----
/*
  Port checker for the converter sequencer top, bound onto every instance.
  Assumes hready is fed back from hreadyout, as with a single slave.
*/
`default_nettype none
module adc_seq_chk (
  input wire logic        sys_clk,     // Clock
  input wire logic        srst,        // Sync reset
  input wire logic        hsel,        // Bus select
  input wire logic [31:0] haddr,       // Bus address
  input wire logic [1:0]  htrans,      // Transfer type
  input wire logic        hwrite,      // Write
  input wire logic        hready,      // Bus ready
  input wire logic [31:0] hrdata,      // Read data
  input wire logic        hreadyout,   // Ready out
  input wire logic        hresp,       // Response
  input wire logic        scanEnable,  // Scan port on
  input wire logic [4:0]  activeChan,  // Active channel
  input wire logic        sampleHold,  // Sample strobe
  input wire logic        convBusy,    // Busy level
  input wire logic [3:0]  upperPinOvr  // Pin override
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_ff;
  logic unmapped_ff;

  // Data phase tracking
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      phase_ff    <= 1'b0;
      unmapped_ff <= 1'b0;
    end
    else if (hready)
    begin
      phase_ff    <= hsel && htrans[1];
      unmapped_ff <= hsel && htrans[1] && !hwrite && (haddr >= 32'h0000_0010);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_bus_ok; hreadyout && !hresp; endproperty
  property p_idle_zero; !phase_ff |-> hrdata == 32'h0; endproperty
  property p_unmapped; unmapped_ff |-> hrdata == 32'h0; endproperty
  property p_lane; hrdata[31:8] == 24'h0; endproperty
  property p_pin_on;
    !$past(srst) && $past(scanEnable, 3) && $past(scanEnable, 4) |-> upperPinOvr == 4'hF;
  endproperty
  property p_pin_off;
    !$past(srst) && !$past(scanEnable, 3) && !$past(scanEnable, 4) |-> upperPinOvr == 4'h0;
  endproperty
  property p_sh_pulse; sampleHold |=> !sampleHold; endproperty
  property p_sh_busy; sampleHold |-> convBusy; endproperty
  property p_rst_out; $past(srst) |-> !convBusy && !sampleHold && activeChan == 5'h0; endproperty
  property p_busy_min; $rose(convBusy) |-> convBusy[*8]; endproperty

  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside data phase");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_lane: assert property (p_lane) else $error("read data above byte lane");
  a_pin_on: assert property (p_pin_on) else $error("pins not overridden");
  a_pin_off: assert property (p_pin_off) else $error("pins overridden");
  a_sh_pulse: assert property (p_sh_pulse) else $error("sample strobe too long");
  a_sh_busy: assert property (p_sh_busy) else $error("sample strobe while idle");
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
  a_busy_min: assert property (p_busy_min) else $error("conversion too short");

  c_conv: cover property ($rose(convBusy));
  c_sample: cover property (sampleHold);
  c_scan: cover property (upperPinOvr == 4'hF);
endmodule

bind adc_conversion_sequencer adc_seq_chk i_adc_seq_chk (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .scanEnable, .activeChan, .sampleHold, .convBusy, .upperPinOvr);
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Testbench for the converter sequencer: register access, conversion timing, free running,
  selection buffering and result locking. Assumes the port checker is bound from its own file.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CTRL = {28'h0, adc_seq_pkg::CTRL_OFFS};
  localparam logic [31:0] SEL  = {28'h0, adc_seq_pkg::SEL_OFFS};
  localparam logic [31:0] RLO  = {28'h0, adc_seq_pkg::RESLO_OFFS};
  localparam logic [31:0] RHI  = {28'h0, adc_seq_pkg::RESHI_OFFS};
  logic        sys_clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [9:0]  convData;
  logic        scanEnable;
  logic [4:0]  activeChan;
  logic [1:0]  activeRef;
  logic        sampleHold;
  logic        convBusy;
  logic [3:0]  upperPinOvr;
  int          miscompares;
  int          totalChecks;

  adc_conversion_sequencer i_adc_conversion_sequencer (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .convData(convData), .scanEnable(scanEnable),
    .activeChan(activeChan), .activeRef(activeRef), .sampleHold(sampleHold), .convBusy(convBusy),
    .upperPinOvr(upperPinOvr));

  task automatic finish_test();
    if (miscompares == 0 && totalChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // Bounded wait: 0 ready, 1 busy, 2 sample strobe
  task automatic waitFor(input int s, input logic lvl, output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (((s == 0) ? hreadyout : (s == 1) ? convBusy : sampleHold) !== lvl && n < 2000);
    if (n >= 2000)
    begin
      miscompares++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    waitFor(0, 1'b1, n);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitFor(0, 1'b1, n);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask

  // Lengths in system cycles, busy rise to fall and strobe to fall
  task automatic convLen(input int expLen, input int expSh);
    int n;
    int m;
    waitFor(1, 1'b1, n);
    waitFor(2, 1'b1, n);
    waitFor(1, 1'b0, m);
    check("conversion length", 32'(n + m), 32'(expLen));
    // Busy falls one register later than the done flag sets
    check("sample to done", 32'(m), 32'(expSh + 1));
  endtask

  task automatic t_regs();
    rd("control reset", CTRL, 32'h0);
    rd("select reset", SEL, 32'h0);
    wr(32'h10, 32'hFF);
    rd("unmapped", 32'h10, 32'h0);
    wr(SEL, 32'h83);
    rd("select", SEL, 32'h83);
    check("channel while off", 32'h0, {27'h0, activeChan});
    wr(CTRL, 32'h80);
    rd("control enabled", CTRL, 32'h80);
    check("channel when on", 32'h3, {27'h0, activeChan});
    check("reference when on", 32'h2, {30'h0, activeRef});
    scanEnable <= 1'b1;
    rd("select", SEL, 32'h83);
    repeat (2) @(posedge sys_clk);
    check("pin override", 32'hF, {28'h0, upperPinOvr});
    scanEnable <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check("pin release", 32'h0, {28'h0, upperPinOvr});
  endtask

  task automatic t_single();
    wr(CTRL, 32'hC0);
    convLen(50, 23);
    rd("done set", CTRL, 32'h90);
    rd("result low", RLO, 32'hA5);
    rd("result high", RHI, 32'h02);
    wr(CTRL, 32'hD0);
    fork
      convLen(26, 23);
      begin
        rd("start held", CTRL, 32'hC0);
        wr(SEL, 32'h84); // after converter cycle
        rd("select", SEL, 32'h84);
        check("channel frozen", 32'h3, {27'h0, activeChan});
      end
    join
    rd("start cleared", CTRL, 32'h90);
    check("channel resumed", 32'h4, {27'h0, activeChan});
  endtask

  task automatic t_lock();
    wr(SEL, 32'hA4);
    rd("left low", RLO, 32'h40);
    convData <= 10'h0F6;
    wr(CTRL, 32'hD2);
    convLen(52, 46);
    rd("done on lost result", CTRL, 32'h92);
    rd("locked low", RLO, 32'h40);
    rd("locked high", RHI, 32'hA9);
    wr(CTRL, 32'hD2);
    convLen(52, 46);
    rd("new low", RLO, 32'h80);
    rd("new high", RHI, 32'h3D);
  endtask

  task automatic t_free();
    int n;
    wr(SEL, 32'h09); // results discarded
    wr(CTRL, 32'hF0);
    waitFor(2, 1'b1, n);
    waitFor(2, 1'b1, n);
    waitFor(2, 1'b1, n);
    check("auto differential period", 32'(n), 32'd28);
    wr(SEL, 32'h02);
    rd("start kept", CTRL, 32'hF0);
    check("channel frozen", 32'h9, {27'h0, activeChan});
    waitFor(2, 1'b1, n);
    check("channel at next sample", 32'h2, {27'h0, activeChan});
    waitFor(2, 1'b1, n);
    check("auto single period", 32'(n), 32'd26);
    wr(CTRL, 32'h90);
    waitFor(1, 1'b0, n);
    rd("free run stopped", CTRL, 32'h90);
    wr(CTRL, 32'h00);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever
      #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    srst        = 1'b1;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    convData    = 10'h2A5;
    scanEnable  = 1'b0;
    miscompares = 0;
    totalChecks = 0;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_single();
    t_lock();
    t_free();
    finish_test();
  end
endmodule
`default_nettype wire
